// >>> verilog/psc_port_strap_map.vh
/*
 * Constants for the port strap configuration block: APB register
 * offsets, field positions, reset values and the strap settle count.
 * Assumes a single 10 MHz core clock and a 32-bit APB bus.
 */
// Overview of operation
// - second channel strap high enables VC1, no sharing
// - strap low disables VC1, VC0 takes buffers
// - polarity strap high turns inversion detection off
// - payload strap selects 512 or 256 byte capability
// - low slot present input means device present
// - refclk strap records common or separate clock
// - slot implemented bit means slot, else chip-to-chip
// - select low runs pins as clock requests
// - request deasserted stops refclk and PLL, L1
// - request asserted restarts refclk, PLL, leaves L1
// - select high drives pins as port status
// - select low L1.1, high status output mode
// - reset initialises all internal state
`ifndef PSC_PORT_STRAP_MAP_VH
`define PSC_PORT_STRAP_MAP_VH

// register byte offsets
`define PSC_OFF_CFG 8'h00
`define PSC_OFF_PM 8'h04
`define PSC_OFF_CTRL 8'h08
`define PSC_OFF_STAT 8'h0c

// configuration register fields
`define PSC_CFG_VC1 0
`define PSC_CFG_SHARE 1
`define PSC_CFG_POLDET 2
`define PSC_CFG_MPS_LO 4
`define PSC_CFG_MPS_HI 6
`define PSC_CFG_COMCLK 7
`define PSC_CFG_MODE 8
`define PSC_CFG_SLOT_LO 9
`define PSC_CFG_SLOT_HI 11
`define PSC_CFG_PRES_LO 12
`define PSC_CFG_PRES_HI 14
`define PSC_CFG_VALID 15

// power register fields
`define PSC_PM_CLK_LO 0
`define PSC_PM_CLK_HI 3
`define PSC_PM_L1_LO 4
`define PSC_PM_L1_HI 7

// control register fields and reset values
`define PSC_CTRL_REQEN_LO 0
`define PSC_CTRL_REQEN_HI 3
`define PSC_CTRL_RST 4'hf

// per-port pin and clock slice reset values
`define PSC_PIN_OUT_RST 1'b1
`define PSC_PIN_OE_RST 1'b0
`define PSC_CLK_ON_RST 1'b1
`define PSC_L1_RST 1'b0

// max payload size capability encodings
`define PSC_MPS_256 3'h1
`define PSC_MPS_512 3'h2

// cycles after reset release before straps are latched
`define PSC_SETTLE_CYC 2'h3

`endif

// >>> verilog/psc_sync.v
/*
 * Two flip-flop level synchroniser, one chain per bit.
 * Assumes inputs are quasi-static levels from pins.
 */
module psc_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	// clock and reset
	input wire sysClk,
	input wire rstn,
	// asynchronous level in, synchronised level out
	input wire [W-1:0] asyncIn,
	output wire [W-1:0] syncOut
);

	genvar i;

	generate
		for (i = 0; i < W; i = i + 1) begin : gBit
			reg meta_q; // first stage, read only by second
			reg stab_q; // second stage, safe to use

			// two stages per bit; reset to the idle pin level
			always @(posedge sysClk or negedge rstn) begin
				if (!rstn) begin
					meta_q <= INIT[i];
					stab_q <= INIT[i];
				end else begin
					meta_q <= asyncIn[i];
					stab_q <= meta_q;
				end
			end

			assign syncOut[i] = stab_q;
		end
	endgenerate

endmodule // psc_sync

// >>> verilog/psc_port_strap.v
/*
 * Port strap configuration for a four-port switch: latches the level
 * straps after reset, reports slot presence, and runs the shared
 * per-port pins either as open-drain clock requests or as status.
 * Assumes straps are static while running, APB on the core clock,
 * and an external pull-up on the clock request wires.
 * Limitation: a strap moved while running is not seen until the
 * next reset; only slot presence follows its pins live.
 */
`include "psc_port_strap_map.vh"

module psc_port_strap (
	// clock and reset
	input wire sysClk,
	input wire rstn,
	// configuration straps from pins
	input wire secondChannelEnableStrap,
	input wire polarityDetectDisableStrap,
	input wire largePayloadStrap,
	input wire commonRefclkStrap,
	input wire [3:1] slotImplementedStrap,
	input wire [3:1] slotPresentN,
	input wire substateOrStatusSelect,
	// shared per-port pins, open drain in clock request mode
	input wire [3:0] refclkRequestNIn,
	output reg [3:0] refclkRequestNOut,
	output reg [3:0] refclkRequestNOe,
	// port core side
	input wire [3:0] linkClkReq,
	input wire [3:0] portStatus,
	// configuration results to the switch core
	output reg vc1Enable,
	output reg vcShareAvail,
	output reg vc0TakesVc1Buf,
	output reg polarityDetectEn,
	output reg [2:0] maxPayloadCap,
	output reg commonRefclk,
	output reg [3:1] slotImplemented,
	output reg [3:1] slotPresent,
	output reg statusMode,
	output reg cfgValid,
	// reference clock and pll control per port
	output reg [3:0] refclkEnable,
	output reg [3:0] pllEnable,
	output reg [3:0] l1Substate,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg pslverr,
	output reg [31:0] prdata
);

	// synchronised pin levels
	wire [7:0] strapSync; // static straps after two flops
	wire [3:1] presSync; // slot present, active low
	wire [3:0] reqSync; // clock request wire level

	// capture sequencing
	reg [1:0] settle_q; // cycles since reset release
	reg [1:0] settle_d;
	reg capture; // one-cycle latch strobe

	// software control
	reg [3:0] reqEn_q; // per-port clock request enable
	reg [3:0] reqEn_d;

	// status pins mirror, registered before leaving
	reg [3:0] statHold_q;

	// apb decode
	wire setup; // first phase of a transfer
	wire access; // second phase, always completes
	wire wrCtrl; // write to control register
	reg addrHit; // address maps to a register
	reg [31:0] rdMux; // read data of the addressed register

	// index of the per-port slices
	genvar p;

	// all strap pins idle low through their pull-downs
	psc_sync #(
		.W(8),
		.INIT(8'h00)
	) uStrapSync (
		.sysClk(sysClk),
		.rstn(rstn),
		.asyncIn({substateOrStatusSelect, slotImplementedStrap,
			commonRefclkStrap, largePayloadStrap,
			polarityDetectDisableStrap, secondChannelEnableStrap}),
		.syncOut(strapSync)
	);

	// presence pins reset as absent
	psc_sync #(
		.W(3),
		.INIT(3'h7)
	) uPresSync (
		.sysClk(sysClk),
		.rstn(rstn),
		.asyncIn(slotPresentN),
		.syncOut(presSync)
	);

	// request wires idle high through the board pull-up
	psc_sync #(
		.W(4),
		.INIT(4'hf)
	) uReqSync (
		.sysClk(sysClk),
		.rstn(rstn),
		.asyncIn(refclkRequestNIn),
		.syncOut(reqSync)
	);

	// settle counter: wait for the synchronisers to fill
	always @* begin
		settle_d = settle_q;
		capture = 1'b0;
		if (settle_q != `PSC_SETTLE_CYC) begin
			settle_d = settle_q + 2'h1;
			// latch on the last step, once the chain holds pin data
			if (settle_q == (`PSC_SETTLE_CYC - 2'h1)) begin
				capture = 1'b1;
			end
		end
	end

	always @(posedge sysClk or negedge rstn) begin
		if (!rstn) begin
			// restart the count on every reset
			settle_q <= 2'h0;
		end else begin
			// count up, then park at the end value
			settle_q <= settle_d;
		end
	end

	// strap latch: sampled once per reset, held until the next
	always @(posedge sysClk or negedge rstn) begin
		if (!rstn) begin
			// defaults are all zero except a 256 byte payload cap
			vc1Enable <= 1'b0;
			vcShareAvail <= 1'b0;
			vc0TakesVc1Buf <= 1'b0;
			polarityDetectEn <= 1'b0;
			maxPayloadCap <= `PSC_MPS_256;
			commonRefclk <= 1'b0;
			slotImplemented <= 3'h0;
			statusMode <= 1'b0;
			cfgValid <= 1'b0;
		end else if (capture) begin
			// vc1 on means its buffers are not lent to vc0
			vc1Enable <= strapSync[0];
			vcShareAvail <= ~strapSync[0];
			vc0TakesVc1Buf <= ~strapSync[0];
			polarityDetectEn <= ~strapSync[1];
			if (strapSync[2]) begin
				maxPayloadCap <= `PSC_MPS_512;
			end else begin
				maxPayloadCap <= `PSC_MPS_256;
			end
			commonRefclk <= strapSync[3];
			slotImplemented <= strapSync[6:4];
			// pin mode is fixed for the whole reset period
			statusMode <= strapSync[7];
			cfgValid <= 1'b1;
		end
	end

	// presence follows the slot live, so hot insertion shows up
	always @(posedge sysClk or negedge rstn) begin
		if (!rstn) begin
			// nothing reported present during reset
			slotPresent <= 3'h0;
		end else begin
			// pin is active low, report is active high
			slotPresent <= ~presSync;
		end
	end

	// control register write path
	always @* begin
		// hold unless software writes
		reqEn_d = reqEn_q;
		if (wrCtrl) begin
			// upper write bits are ignored
			reqEn_d = pwdata[`PSC_CTRL_REQEN_HI:`PSC_CTRL_REQEN_LO];
		end
	end

	always @(posedge sysClk or negedge rstn) begin
		if (!rstn) begin
			// every port may ask for clock after reset
			reqEn_q <= `PSC_CTRL_RST;
		end else begin
			reqEn_q <= reqEn_d;
		end
	end

	// per-port slices: status mirror, pin driver and clock gating
	generate
		for (p = 0; p < 4; p = p + 1) begin : gPort
			wire askClk; // core asks and software allows it
			wire sideband; // pin runs as a clock request
			wire reqIdle; // nobody pulls this port's wire

			// software can veto a core request per port
			assign askClk = linkClkReq[p] & reqEn_q[p];
			// only a known request mode may gate the clock
			assign sideband = cfgValid & ~statusMode;
			// the pull-up wins only when every party lets go
			assign reqIdle = reqSync[p];

			// status mirror, one flop so the pin sees no core glitch
			always @(posedge sysClk or negedge rstn) begin
				if (!rstn) begin
					statHold_q[p] <= 1'b0;
				end else begin
					statHold_q[p] <= portStatus[p];
				end
			end

			// shared pin driver
			always @(posedge sysClk or negedge rstn) begin
				if (!rstn) begin
					// released until the mode is known
					refclkRequestNOut[p] <= `PSC_PIN_OUT_RST;
					refclkRequestNOe[p] <= `PSC_PIN_OE_RST;
				end else if (!cfgValid) begin
					// no drive before the straps are known
					refclkRequestNOut[p] <= 1'b1;
					refclkRequestNOe[p] <= 1'b0;
				end else if (statusMode) begin
					// debug header view of each port
					refclkRequestNOut[p] <= statHold_q[p];
					refclkRequestNOe[p] <= 1'b1;
				end else begin
					// open drain: pull low to ask, else let go
					refclkRequestNOut[p] <= 1'b0;
					refclkRequestNOe[p] <= askClk;
				end
			end

			// clock and pll gating from the wired-and request level
			always @(posedge sysClk or negedge rstn) begin
				if (!rstn) begin
					// clock runs through reset so training can start
					refclkEnable[p] <= `PSC_CLK_ON_RST;
					pllEnable[p] <= `PSC_CLK_ON_RST;
					l1Substate[p] <= `PSC_L1_RST;
				end else if (!sideband) begin
					// no substate without the request sideband
					refclkEnable[p] <= 1'b1;
					pllEnable[p] <= 1'b1;
					l1Substate[p] <= 1'b0;
				end else if (reqIdle) begin
					// nobody pulls the wire: gate clock and pll
					refclkEnable[p] <= 1'b0;
					pllEnable[p] <= 1'b0;
					l1Substate[p] <= 1'b1;
				end else begin
					// any party pulls low: clock back, leave L1
					refclkEnable[p] <= 1'b1;
					pllEnable[p] <= 1'b1;
					l1Substate[p] <= 1'b0;
				end
			end
		end
	endgenerate

	// apb phases; every access completes without wait states
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign pready = 1'b1;
	// a write lands only in the access phase, at the completing edge
	assign wrCtrl = access & pwrite & (paddr == `PSC_OFF_CTRL);

	// read multiplexer, unused bits read zero
	always @* begin
		rdMux = 32'h0;
		addrHit = 1'b1;
		case (paddr)
			`PSC_OFF_CFG: begin
				// latched straps, live presence and the valid flag
				rdMux[`PSC_CFG_VC1] = vc1Enable;
				rdMux[`PSC_CFG_SHARE] = vcShareAvail;
				rdMux[`PSC_CFG_POLDET] = polarityDetectEn;
				rdMux[`PSC_CFG_MPS_HI:`PSC_CFG_MPS_LO] = maxPayloadCap;
				rdMux[`PSC_CFG_COMCLK] = commonRefclk;
				rdMux[`PSC_CFG_MODE] = statusMode;
				rdMux[`PSC_CFG_SLOT_HI:`PSC_CFG_SLOT_LO] = slotImplemented;
				rdMux[`PSC_CFG_PRES_HI:`PSC_CFG_PRES_LO] = slotPresent;
				rdMux[`PSC_CFG_VALID] = cfgValid;
			end
			`PSC_OFF_PM: begin
				// per-port gating state as applied to the clocks
				rdMux[`PSC_PM_CLK_HI:`PSC_PM_CLK_LO] = refclkEnable;
				rdMux[`PSC_PM_L1_HI:`PSC_PM_L1_LO] = l1Substate;
			end
			`PSC_OFF_CTRL: begin
				// software request enables
				rdMux[`PSC_CTRL_REQEN_HI:`PSC_CTRL_REQEN_LO] = reqEn_q;
			end
			`PSC_OFF_STAT: begin
				// raw synchronised wire level, for board debug
				rdMux[3:0] = reqSync;
			end
			default: begin
				// unmapped or unaligned offset answers with an error
				addrHit = 1'b0;
			end
		endcase
	end

	// read data and error are set up in the setup cycle and held
	always @(posedge sysClk or negedge rstn) begin
		if (!rstn) begin
			// bus idle after reset
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (setup) begin
			// read-only registers ignore writes, no error
			if (pwrite) begin
				prdata <= 32'h0;
			end else begin
				prdata <= rdMux;
			end
			pslverr <= ~addrHit;
		end else if (access) begin
			// hold through the access edge, clear after
			prdata <= prdata;
			pslverr <= pslverr;
		end else begin
			// idle bus reads zero so stale data never leaks
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end
	end

endmodule // psc_port_strap

// >>> dv/psc_pins_model.sv
/*
 * Far side of the shared clock request wires: pull-up plus
 * downstream devices that can pull a wire low.
 * Assumes the device only pulls low while its enable is high.
 */
module psc_pins_model (
	// device side of the pins
	input wire [3:0] oe,
	input wire [3:0] out,
	// far side asks for clock by pulling low
	input wire [3:0] pull,
	// resolved wire level
	output wire [3:0] level
);
	timeunit 1ns;
	timeprecision 1ns;
	// released wire rises through the pull-up, any party pulls low
	assign level = ~((oe & ~out) | pull);
endmodule // psc_pins_model

// >>> dv/psc_port_strap_chk.sv
/*
 * Assertions on the port strap block, bound to its ports.
 * Assumes straps only change while cfgValid is low or held.
 */
module psc_port_strap_chk (
	// clock and reset
	input wire sysClk,
	input wire rstn,
	// straps and pins
	input wire secondChannelEnableStrap,
	input wire polarityDetectDisableStrap,
	input wire largePayloadStrap,
	input wire commonRefclkStrap,
	input wire [3:1] slotImplementedStrap,
	input wire [3:1] slotPresentN,
	input wire substateOrStatusSelect,
	input wire [3:0] refclkRequestNIn,
	input wire [3:0] refclkRequestNOut,
	input wire [3:0] refclkRequestNOe,
	input wire [3:0] portStatus,
	// results
	input wire vc1Enable,
	input wire vcShareAvail,
	input wire vc0TakesVc1Buf,
	input wire polarityDetectEn,
	input wire [2:0] maxPayloadCap,
	input wire commonRefclk,
	input wire [3:1] slotImplemented,
	input wire [3:1] slotPresent,
	input wire statusMode,
	input wire cfgValid,
	input wire [3:0] refclkEnable,
	input wire [3:0] pllEnable,
	input wire [3:0] l1Substate,
	// apb
	input wire psel,
	input wire penable,
	input wire [7:0] paddr,
	input wire pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] strapQ; // own copy of latched straps
	default clocking cb @(posedge sysClk); endclocking
	default disable iff (!rstn);
	// follow pins until valid, so later pin changes must not leak
	always_ff @(posedge sysClk) if (!cfgValid) strapQ <= {
		substateOrStatusSelect, slotImplementedStrap, commonRefclkStrap,
		largePayloadStrap, polarityDetectDisableStrap,
		secondChannelEnableStrap};
	vc1_on_a: assert property (
		cfgValid && strapQ[0] |-> vc1Enable && !vcShareAvail)
		else $error("vc1 enable wrong");
	vc1_off_a: assert property (
		cfgValid && !strapQ[0] |-> !vc1Enable && vc0TakesVc1Buf)
		else $error("vc1 disable wrong");
	pol_detect_a: assert property (
		cfgValid |-> polarityDetectEn == !strapQ[1])
		else $error("polarity detect wrong");
	payload_cap_a: assert property (
		cfgValid |-> maxPayloadCap == (strapQ[2] ? 3'h2 : 3'h1))
		else $error("payload cap wrong");
	slot_presence_a: assert property (
		cfgValid |-> slotPresent == ~$past(slotPresentN, 3))
		else $error("presence wrong");
	com_clk_a: assert property (
		cfgValid |-> commonRefclk == strapQ[3])
		else $error("common clock wrong");
	slot_imp_a: assert property (
		cfgValid |-> slotImplemented == strapQ[6:4])
		else $error("slot implemented wrong");
	mode_sel_a: assert property (
		cfgValid |-> statusMode == strapQ[7])
		else $error("mode select wrong");
	od_drive_a: assert property (
		!statusMode |-> (refclkRequestNOe & refclkRequestNOut) == 4'h0)
		else $error("request pin driven high");
	clk_gate_a: assert property (
		cfgValid && $past(cfgValid, 3) && !statusMode |->
		refclkEnable == ~$past(refclkRequestNIn, 3) &&
		pllEnable == ~$past(refclkRequestNIn, 3) &&
		l1Substate == $past(refclkRequestNIn, 3))
		else $error("clock gating wrong");
	status_out_a: assert property (
		statusMode && $past(statusMode, 2) |-> refclkRequestNOe == 4'hf
		&& refclkRequestNOut == $past(portStatus, 2))
		else $error("status pins wrong");
	apb_err_a: assert property (psel && !penable |=> pslverr ==
		($past(paddr) > 8'h0c || $past(paddr[1:0]) != 2'h0))
		else $error("apb error flag wrong");
endmodule // psc_port_strap_chk

bind psc_port_strap psc_port_strap_chk psc_port_strap_chk_inst (.*);

// >>> dv/psc_port_strap_tb_top.sv
/*
 * Self-checking bench for the port strap block: random straps
 * per reset, pin traffic in both modes, apb register reads.
 * Assumes the pull-up wire model and the bound checker.
 */
module psc_port_strap_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sysClk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] linkClkReq = 4'h0;
	logic [3:0] portStatus = 4'h0;
	logic [3:0] extPull = 4'h0; // far side requests
	logic [10:0] strap = 11'h380; // packed strap levels
	logic [31:0] st = 32'h9; // xorshift state
	logic [31:0] q, r, m;
	logic [10:0] s;
	logic e;
	int n_mismatch = 0;
	int cmp_count = 0;
	wire secondChannelEnableStrap = strap[0];
	wire polarityDetectDisableStrap = strap[1];
	wire largePayloadStrap = strap[2];
	wire commonRefclkStrap = strap[3];
	wire [3:1] slotImplementedStrap = strap[6:4];
	wire [3:1] slotPresentN = strap[9:7];
	wire substateOrStatusSelect = strap[10];
	wire [3:0] refclkRequestNIn, refclkRequestNOut, refclkRequestNOe;
	wire [3:0] refclkEnable, pllEnable, l1Substate;
	wire [3:1] slotImplemented, slotPresent;
	wire [2:0] maxPayloadCap;
	wire vc1Enable, vcShareAvail, vc0TakesVc1Buf, polarityDetectEn;
	wire commonRefclk, statusMode, cfgValid, pready, pslverr;
	wire [31:0] prdata;
	// core clock, 100 ns period
	always #50 sysClk = ~sysClk;
	psc_port_strap psc_port_strap_inst (.*);
	psc_pins_model psc_pins_model_inst (.oe(refclkRequestNOe),
		.out(refclkRequestNOut), .pull(extPull), .level(refclkRequestNIn));
	function automatic logic [31:0] xs();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction
	// expected configuration word from strap levels
	function automatic logic [31:0] cfg_exp(logic [10:0] v);
		return {16'h0, 1'b1, ~v[9:7], v[6:4], v[10], v[3],
			v[2] ? 3'h2 : 3'h1, 1'b0, ~v[1], 1'b0, v[0]};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge sysClk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sysClk);
		penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge sysClk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// new straps are applied while reset is held
	task rst_run(input logic [10:0] v);
		@(posedge sysClk);
		rstn <= 1'b0;
		strap <= v;
		repeat (6) @(posedge sysClk);
		chk(cfgValid, 1'b0);
		chk(refclkRequestNOe, 4'h0);
		chk(refclkEnable, 4'hf);
		rstn <= 1'b1;
		repeat (6) @(posedge sysClk);
	endtask
	task status_test();
		q = xs();
		portStatus <= q[3:0];
		linkClkReq <= q[7:4];
		repeat (4) @(posedge sysClk);
		chk(refclkRequestNOut, q[3:0]);
		chk(refclkRequestNOe, 4'hf);
		chk(refclkEnable, 4'hf);
		chk(pllEnable, 4'hf);
	endtask
	task req_test();
		q = xs();
		linkClkReq <= q[3:0];
		extPull <= q[7:4];
		repeat (6) @(posedge sysClk);
		chk(refclkEnable, q[3:0] | q[7:4]);
		chk(pllEnable, q[3:0] | q[7:4]);
		chk(l1Substate, {28'h0, ~(q[3:0] | q[7:4])});
		apb(1'b0, 8'h0c, 32'h0, r, e);
		chk(r, {28'h0, ~(q[3:0] | q[7:4])});
		apb(1'b0, 8'h04, 32'h0, r, e);
		chk(r, {24'h0, ~(q[3:0] | q[7:4]), q[3:0] | q[7:4]});
		// request enables off: core requests must be ignored
		apb(1'b1, 8'h08, 32'h0, r, e);
		apb(1'b0, 8'h08, 32'h0, r, e);
		chk(r, 32'h0);
		repeat (6) @(posedge sysClk);
		chk(refclkEnable, q[7:4]);
		chk(pllEnable, q[7:4]);
		chk(l1Substate, {28'h0, ~q[7:4]});
		extPull <= 4'h0;
	endtask
	task tally_and_finish();
		$display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		tally_and_finish();
	end
	// corners first, then random straps
	initial begin
		for (int i = 0; i < 6; i++) begin
			s = (i == 0) ? 11'h380 : (i == 1) ? 11'h47f : xs();
			rst_run(s);
			m = s[0] ? 32'hfffffff7 : 32'hfffffff5;
			apb(1'b0, 8'h00, 32'h0, r, e);
			chk(r & m, cfg_exp(s) & m);
			apb(1'b0, 8'h08, 32'h0, r, e);
			chk(r, 32'hf);
			if (s[10]) status_test(); else req_test();
			// pins move without reset: only presence follows
			q = xs();
			strap <= q[10:0];
			repeat (5) @(posedge sysClk);
			apb(1'b0, 8'h00, 32'h0, r, e);
			chk(r & m, cfg_exp({s[10], q[9:7], s[6:0]}) & m);
			$display("test %0d done", i);
		end
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		tally_and_finish();
	end
endmodule // psc_port_strap_tb_top
